/* File: rtl/can_mode_pkg.sv */
// Shared constants, types and register layout for the CAN mode controller
package can_mode_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W   = 4;
    localparam logic [3:0]  OFS_MCR  = 4'h0;
    localparam logic [3:0]  OFS_GSR  = 4'h4;
    localparam logic [3:0]  OFS_IFR  = 4'h8;
    localparam logic [3:0]  OFS_BTIM = 4'hc;

    // ==========================================================
    // Field positions
    localparam int MCR_SUSPEND_ACTION_SELECT_SEL  = 13;
    localparam int MCR_CFG_REQ   = 12;
    localparam int MCR_PD_REQ    = 11;
    localparam int MCR_WAKE_BUS  = 9;
    localparam int GSR_ERR_PASS  = 7;
    localparam int GSR_BUS_OFF   = 6;
    localparam int GSR_SUSPEND_ACTION_SELECT_ACK  = 5;
    localparam int GSR_CFG_EN    = 4;
    localparam int GSR_PD_ACK    = 3;
    localparam int IFR_WAKE_FLAG = 3;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [31:0] MCR_RESET  = 32'h0000_1000;
    localparam logic [31:0] MCR_MASK   = 32'h0000_3a00;
    localparam logic [31:0] IFR_RESET  = 32'h0000_0000;
    localparam logic [31:0] BTIM_RESET = 32'h0000_0000;

    // ==========================================================
    // Timing counts
    localparam int REC_BITS   = 11;
    localparam int BO_SEQS    = 128;
    localparam int TQ_PER_BIT = 8;

    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [7:0] {
        ST_CONFIG = 8'h01,
        ST_RESYNC = 8'h02,
        ST_ACTIVE = 8'h04,
        ST_PDWAIT = 8'h08,
        ST_PDOWN  = 8'h10,
        ST_WAKE   = 8'h20,
        ST_SWAIT  = 8'h40,
        ST_SUSPEND_ACTION_SELECT   = 8'h80
    } mode_e;

    typedef struct packed {
        logic txBusy;
        logic busOff;
        logic errPassive;
    } frame_status_s;

    typedef struct packed {
        logic busActive;
        logic freeze;
        logic wakeIrq;
        logic busOnReq;
    } mode_out_s;

endpackage : can_mode_pkg

/* File: rtl/can_mode_control.sv */
// CAN mode controller: configuration, power-down, wake-up and suspend
// ==========================================================
`timescale 1ns/1ns
module can_mode_control #(
    parameter int BTIM_W = 16
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    // AXI4-Lite write
    input  wire logic [can_mode_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // AXI4-Lite read
    input  wire logic [can_mode_pkg::ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Bus pin and debug
    input  wire logic                          canRx,
    input  wire logic                          dbgSuspend,
    // Frame engine
    input  can_mode_pkg::frame_status_s        feStatus,
    output can_mode_pkg::mode_out_s            modeOut,
    output logic [BTIM_W-1:0]                  bitTiming
);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] laneMask(input logic [3:0] s);
        laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : laneMask

    function automatic logic isMapped(input logic [can_mode_pkg::ADDR_W-1:0] a);
        isMapped = (a == can_mode_pkg::OFS_MCR) || (a == can_mode_pkg::OFS_GSR)
                || (a == can_mode_pkg::OFS_IFR) || (a == can_mode_pkg::OFS_BTIM);
    endfunction : isMapped

    localparam logic [3:0] REC_LAST = 4'(can_mode_pkg::REC_BITS - 1);
    localparam logic [6:0] SEQ_LAST = 7'(can_mode_pkg::BO_SEQS - 1);
    localparam logic [15:0] TQ_N    = 16'(can_mode_pkg::TQ_PER_BIT);

    // ==========================================================
    // Input synchronisers
    logic rxMeta;
    logic rxSync;
    logic suspMeta;
    logic suspSync;

    always_ff @(posedge core_clk) begin
        rxMeta   <= canRx;
        rxSync   <= rxMeta;
        suspMeta <= dbgSuspend;
        suspSync <= suspMeta;
    end

    // ==========================================================
    // Register storage
    logic [31:0]              mcrQ;
    logic [31:0]              mcrD;
    logic                     wakeFlagQ;
    logic                     wakeFlagD;
    logic [BTIM_W-1:0]        btimQ;
    logic [BTIM_W-1:0]        btimD;
    logic                     cfgEnQ;
    logic                     pdAckQ;
    logic                     suspAckQ;
    can_mode_pkg::mode_e      stateQ;
    can_mode_pkg::mode_e      stateD;

    wire cfgReq   = mcrQ[can_mode_pkg::MCR_CFG_REQ];
    wire pdReq    = mcrQ[can_mode_pkg::MCR_PD_REQ];
    wire wakeBus  = mcrQ[can_mode_pkg::MCR_WAKE_BUS];
    wire softSusp = mcrQ[can_mode_pkg::MCR_SUSPEND_ACTION_SELECT_SEL];
    wire rxDom    = ~rxSync;

    // ==========================================================
    // Bit-rate enable
    logic [15:0] divQ;
    wire  [15:0] divPeriod = 16'((16'(btimQ[7:0]) + 16'h0001) * TQ_N - 16'h0001);
    wire         bitTick   = (divQ == 16'h0000);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            divQ <= 16'h0000;
        end else begin
            divQ <= bitTick ? divPeriod : divQ - 16'h0001;
        end
    end

    // ==========================================================
    // Idle detection: consecutive recessive bits before joining
    logic [3:0] idleCntQ;
    wire idleWait = (stateQ == can_mode_pkg::ST_RESYNC) || (stateQ == can_mode_pkg::ST_WAKE);
    wire idleDone = idleWait && bitTick && rxSync && (idleCntQ == REC_LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst || !idleWait || idleDone) begin
            idleCntQ <= 4'h0;
        end else if (bitTick) begin
            idleCntQ <= rxSync ? idleCntQ + 4'h1 : 4'h0;
        end
    end

    // ==========================================================
    // Bus-off recovery, kept running through suspend
    logic [3:0] boBitQ;
    logic [6:0] boSeqQ;
    wire seqEnd = feStatus.busOff && bitTick && rxSync && (boBitQ == REC_LAST);
    wire boDone = seqEnd && (boSeqQ == SEQ_LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst || !feStatus.busOff || boDone) begin
            boBitQ <= 4'h0;
            boSeqQ <= 7'h00;
        end else if (seqEnd) begin
            boBitQ <= 4'h0;
            boSeqQ <= boSeqQ + 7'h01;
        end else if (bitTick) begin
            boBitQ <= rxSync ? boBitQ + 4'h1 : 4'h0;
        end
    end

    // ==========================================================
    // Mode sequencer
    wire softReq  = suspSync && softSusp;
    wire pdWake   = (stateQ == can_mode_pkg::ST_PDOWN) && rxDom;
    wire autoWake = pdWake && wakeBus;

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            can_mode_pkg::ST_CONFIG: begin
                if (!cfgReq) stateD = can_mode_pkg::ST_RESYNC;
            end
            can_mode_pkg::ST_RESYNC: begin
                if (cfgReq) stateD = can_mode_pkg::ST_CONFIG;
                else if (idleDone) stateD = can_mode_pkg::ST_ACTIVE;
            end
            can_mode_pkg::ST_ACTIVE: begin
                if (cfgReq) begin
                    stateD = can_mode_pkg::ST_CONFIG;
                end else if (pdReq) begin
                    stateD = feStatus.txBusy ? can_mode_pkg::ST_PDWAIT
                                             : can_mode_pkg::ST_PDOWN;
                end else if (softReq) begin
                    if (feStatus.busOff || !feStatus.txBusy) begin
                        stateD = can_mode_pkg::ST_SUSPEND_ACTION_SELECT;
                    end else begin
                        stateD = can_mode_pkg::ST_SWAIT;
                    end
                end
            end
            can_mode_pkg::ST_PDWAIT: begin
                if (!pdReq) stateD = can_mode_pkg::ST_ACTIVE;
                else if (!feStatus.txBusy) stateD = can_mode_pkg::ST_PDOWN;
            end
            can_mode_pkg::ST_PDOWN: begin
                if (autoWake) stateD = can_mode_pkg::ST_WAKE;
                else if (!pdReq) stateD = can_mode_pkg::ST_WAKE;
            end
            can_mode_pkg::ST_WAKE: begin
                if (idleDone) stateD = can_mode_pkg::ST_ACTIVE;
            end
            can_mode_pkg::ST_SWAIT: begin
                if (!softReq) stateD = can_mode_pkg::ST_ACTIVE;
                else if (!feStatus.txBusy) stateD = can_mode_pkg::ST_SUSPEND_ACTION_SELECT;
            end
            can_mode_pkg::ST_SUSPEND_ACTION_SELECT: begin
                if (!softReq) stateD = can_mode_pkg::ST_RESYNC;
            end
            default: begin
                stateD = can_mode_pkg::ST_CONFIG;
            end
        endcase
    end

    // ==========================================================
    // AXI4-Lite slave: address and data may arrive in either order
    logic                            awReadyQ;
    logic                            wReadyQ;
    logic                            bValidQ;
    logic [1:0]                      bRespQ;
    logic [can_mode_pkg::ADDR_W-1:0] awAddrQ;
    logic [31:0]                     wDataQ;
    logic [3:0]                      wStrbQ;
    logic                            arReadyQ;
    logic                            rValidQ;
    logic [31:0]                     rDataQ;
    logic [1:0]                      rRespQ;

    wire wrFire = !awReadyQ && !wReadyQ && !bValidQ;
    wire [31:0] wMask = wDataQ & laneMask(wStrbQ);
    wire [31:0] keep  = ~laneMask(wStrbQ);
    wire mcrWr  = wrFire && (awAddrQ == can_mode_pkg::OFS_MCR);
    wire ifrWr  = wrFire && (awAddrQ == can_mode_pkg::OFS_IFR);
    wire btimWr = wrFire && (awAddrQ == can_mode_pkg::OFS_BTIM);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awReadyQ <= 1'b1;
            wReadyQ  <= 1'b1;
            bValidQ  <= 1'b0;
            bRespQ   <= can_mode_pkg::RESP_OKAY;
            awAddrQ  <= '0;
            wDataQ   <= 32'h0000_0000;
            wStrbQ   <= 4'h0;
        end else begin
            if (awvalid && awReadyQ) begin
                awAddrQ  <= awaddr;
                awReadyQ <= 1'b0;
            end
            if (wvalid && wReadyQ) begin
                wDataQ  <= wdata;
                wStrbQ  <= wstrb;
                wReadyQ <= 1'b0;
            end
            if (wrFire) begin
                bValidQ <= 1'b1;
                bRespQ  <= isMapped(awAddrQ) ? can_mode_pkg::RESP_OKAY
                                             : can_mode_pkg::RESP_SLVERR;
            end
            if (bValidQ && bready) begin
                bValidQ  <= 1'b0;
                awReadyQ <= 1'b1;
                wReadyQ  <= 1'b1;
            end
        end
    end

    // Status word gathered from live state
    wire [31:0] gsrWord = (32'(cfgEnQ)             << can_mode_pkg::GSR_CFG_EN)
                        | (32'(pdAckQ)             << can_mode_pkg::GSR_PD_ACK)
                        | (32'(suspAckQ)           << can_mode_pkg::GSR_SUSPEND_ACTION_SELECT_ACK)
                        | (32'(feStatus.busOff)    << can_mode_pkg::GSR_BUS_OFF)
                        | (32'(feStatus.errPassive) << can_mode_pkg::GSR_ERR_PASS);
    wire [31:0] ifrWord = 32'(wakeFlagQ) << can_mode_pkg::IFR_WAKE_FLAG;

    wire [31:0] rdMux =
        (araddr == can_mode_pkg::OFS_MCR)  ? mcrQ :
        (araddr == can_mode_pkg::OFS_GSR)  ? gsrWord :
        (araddr == can_mode_pkg::OFS_IFR)  ? ifrWord :
        (araddr == can_mode_pkg::OFS_BTIM) ? 32'(btimQ) : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arReadyQ <= 1'b1;
            rValidQ  <= 1'b0;
            rDataQ   <= 32'h0000_0000;
            rRespQ   <= can_mode_pkg::RESP_OKAY;
        end else if (arvalid && arReadyQ) begin
            arReadyQ <= 1'b0;
            rValidQ  <= 1'b1;
            rDataQ   <= rdMux;
            rRespQ   <= isMapped(araddr) ? can_mode_pkg::RESP_OKAY
                                         : can_mode_pkg::RESP_SLVERR;
        end else if (rValidQ && rready) begin
            rValidQ  <= 1'b0;
            arReadyQ <= 1'b1;
        end
    end

    // ==========================================================
    // Control register updates
    wire [31:0] mcrWrVal = ((mcrQ & keep) | wMask) & can_mode_pkg::MCR_MASK;

    always_comb begin
        mcrD = mcrWr ? mcrWrVal : mcrQ;
        // Hardware wake clear beats a racing software write
        if (autoWake) mcrD[can_mode_pkg::MCR_PD_REQ] = 1'b0;
    end

    // Set wins over a write-one-to-clear in the same cycle
    wire wakeClr = ifrWr && wMask[can_mode_pkg::IFR_WAKE_FLAG];
    assign wakeFlagD = pdWake || (wakeFlagQ && !wakeClr);

    // Timing only changes while configuration is confirmed
    assign btimD = (btimWr && cfgEnQ) ? BTIM_W'((32'(btimQ) & keep) | wMask) : btimQ;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mcrQ      <= can_mode_pkg::MCR_RESET;
            wakeFlagQ <= can_mode_pkg::IFR_RESET[can_mode_pkg::IFR_WAKE_FLAG];
            btimQ     <= BTIM_W'(can_mode_pkg::BTIM_RESET);
            stateQ    <= can_mode_pkg::ST_CONFIG;
        end else begin
            mcrQ      <= mcrD;
            wakeFlagQ <= wakeFlagD;
            btimQ     <= btimD;
            stateQ    <= stateD;
        end
    end

    // ==========================================================
    // Status and outputs, all registered; all but wakeIrq and busOnReq from the next state
    // Freeze is an enable to the frame engine; the clock keeps running
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfgEnQ   <= 1'b1;
            pdAckQ   <= 1'b0;
            suspAckQ <= 1'b0;
            modeOut  <= '0;
        end else begin
            cfgEnQ            <= (stateD == can_mode_pkg::ST_CONFIG);
            pdAckQ            <= (stateD == can_mode_pkg::ST_PDOWN);
            suspAckQ          <= (stateD == can_mode_pkg::ST_SUSPEND_ACTION_SELECT);
            modeOut.busActive <= (stateD == can_mode_pkg::ST_ACTIVE)
                              || (stateD == can_mode_pkg::ST_PDWAIT)
                              || (stateD == can_mode_pkg::ST_SWAIT);
            modeOut.freeze    <= (stateD == can_mode_pkg::ST_SUSPEND_ACTION_SELECT);
            modeOut.wakeIrq   <= wakeFlagD && wakeBus;
            modeOut.busOnReq  <= boDone;
        end
    end

    assign awready   = awReadyQ;
    assign wready    = wReadyQ;
    assign bvalid    = bValidQ;
    assign bresp     = bRespQ;
    assign arready   = arReadyQ;
    assign rvalid    = rValidQ;
    assign rdata     = rDataQ;
    assign rresp     = rRespQ;
    assign bitTiming = btimQ;

endmodule : can_mode_control

/* File: dv/can_mode_control_chk.sv */
// Port-level assertions for the CAN mode controller
`timescale 1ns/1ns
module can_mode_control_chk (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    // Register bus handshakes
    input wire logic                   awvalid,
    input wire logic                   awready,
    input wire logic                   wvalid,
    input wire logic                   wready,
    input wire logic                   bvalid,
    input wire logic                   arvalid,
    input wire logic                   arready,
    input wire logic                   rvalid,
    input wire logic                   rready,
    // Bus pin and frame engine
    input wire logic                   canRx,
    input can_mode_pkg::frame_status_s feStatus,
    input can_mode_pkg::mode_out_s     modeOut
);
    // ==========================================================
    // Run lengths
    // Slack covers the bit tick phase against the first recessive clock
    localparam int REC_MIN = 70;
    localparam int BO_MIN  = 11200;
    logic [6:0]  recRun_q;
    logic [13:0] boRun_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !canRx) recRun_q <= '0;
        else if (recRun_q != 7'h7f) recRun_q <= recRun_q + 7'h01;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !feStatus.busOff) boRun_q <= '0;
        else if (boRun_q != 14'h3fff) boRun_q <= boRun_q + 14'h0001;
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence arTaken;
        arvalid && arready;
    endsequence

    AST_RESET_IDLE: assert property ($fell(sys_rst) |-> modeOut == '0 && !bvalid)
        else $error("mode outputs not clear after reset");
    AST_WRITE_ANSWER: assert property (wrTaken |=> ##1 bvalid)
        else $error("write answer late");
    AST_READ_ANSWER: assert property (arTaken |=> rvalid)
        else $error("read answer late");
    AST_READ_RETIRE: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read answer not retired");
    AST_FREEZE_QUIET: assert property (modeOut.freeze |-> !modeOut.busActive)
        else $error("bus active while frozen");
    AST_FREEZE_AFTER_TX: assert property ($rose(modeOut.freeze) |->
        !$past(feStatus.txBusy) || $past(feStatus.busOff))
        else $error("freeze during a frame");
    AST_RESYNC_WAIT: assert property ($rose(modeOut.busActive) |-> recRun_q >= REC_MIN)
        else $error("bus active without recessive run");
    AST_WAKE_CAUSE: assert property ($rose(modeOut.wakeIrq) |-> !$past(canRx, 3))
        else $error("wake request without dominant level");
    AST_BUSON_PULSE: assert property (modeOut.busOnReq |->
        $past(feStatus.busOff) ##1 !modeOut.busOnReq)
        else $error("bus-on request not a single pulse");
    AST_BUSON_COUNT: assert property (modeOut.busOnReq |-> boRun_q >= BO_MIN)
        else $error("bus-on request too early");
endmodule : can_mode_control_chk

/* File: dv/can_bus_node.sv */
// Remote bus node: idles recessive, sends dominant bursts on request
`timescale 1ns/1ns
module can_bus_node (
    // Clock
    input  wire logic       core_clk,
    // Burst request
    input  wire logic       burstGo,
    input  wire logic [7:0] burstLen,
    // Bus level
    output logic            canRx
);
    logic [7:0] left_q = 8'h00;

    // Released bus floats recessive through the termination pull
    assign canRx = (left_q == 8'h00);

    always @(posedge core_clk) begin
        if (burstGo) left_q <= burstLen;
        else if (left_q != 8'h00) left_q <= left_q - 8'h01;
    end
endmodule : can_bus_node

/* File: dv/can_mode_control_bench.sv */
// Self-checking bench for the CAN mode controller
`timescale 1ns/1ns
module can_mode_control_bench;
    // ==========================================================
    // Signals
    localparam logic SOFT_SEL = 1'h1;  // Select level taken as soft suspend
    localparam int   BA = 3, FRZ = 2, WIRQ = 1, BON = 0;
    logic                        core_clk = 1'h0, sys_rst = 1'h1;
    logic [3:0]                  awaddr = '0, araddr = '0, wstrb = 4'hf;
    logic                        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic                        awready, wready, bvalid, arready, rvalid, canRx;
    logic [31:0]                 wdata = '0, rdata, rd, tmp;
    logic [1:0]                  bresp, rresp, rsp;
    logic                        dbgSuspend = 0, burstGo = 0;
    logic [7:0]                  burstLen = 8'h08;
    can_mode_pkg::frame_status_s feStatus = '0;
    can_mode_pkg::mode_out_s     modeOut;
    logic [15:0]                 bitTiming;
    int                          mismatches = 0, checks = 0, cycles = 0, n, n0;

    can_mode_control i_dut (.core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .canRx, .dbgSuspend, .feStatus, .modeOut, .bitTiming);
    can_bus_node i_node (.core_clk, .burstGo, .burstLen, .canRx);

    // ==========================================================
    // Helpers
    task automatic err(input string m);
        $display("[ERR] %0t %s", $time, m);
        mismatches++;
    endtask : err
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) err($sformatf("word %h, expected %h", got, exp));
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) err($sformatf("bit %b, expected %b", got, exp));
    endtask : cmp_bit
    // Ready is registered, so the level seen mid-cycle is what the next edge takes
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic aw, w, ar, done;
        int k;
        k = 0;
        @(posedge core_clk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        do begin
            @(negedge core_clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            ar = arvalid && arready;
            done = (bready && bvalid) || (rready && rvalid);
            rd = rdata;
            rsp = wr ? bresp : rresp;
            @(posedge core_clk);
            awvalid <= awvalid && !aw;
            wvalid <= wvalid && !w;
            arvalid <= arvalid && !ar;
            bready <= bready && !done;
            rready <= rready && !done;
            k++;
        end while (!done && k < 100);
        if (!done) err("bus answer missing");
    endtask : axi
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        axi(1'h1, a, d);
        cmp_word({30'h0, rsp}, {30'h0, can_mode_pkg::RESP_OKAY});
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        axi(1'h0, a, 32'h0);
        cmp_word({30'h0, rsp}, {30'h0, can_mode_pkg::RESP_OKAY});
    endtask : rd_reg
    task automatic wait_mode(input int idx, input logic v, input int lim);
        n = 0;
        while (modeOut[idx] !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        cmp_bit(modeOut[idx], v);
    endtask : wait_mode
    function automatic logic [31:0] mcr_exp(input logic cfg, pd, wake, suspend_action_select);
        mcr_exp = '0;
        mcr_exp[can_mode_pkg::MCR_CFG_REQ] = cfg;
        mcr_exp[can_mode_pkg::MCR_PD_REQ] = pd;
        mcr_exp[can_mode_pkg::MCR_WAKE_BUS] = wake;
        mcr_exp[can_mode_pkg::MCR_SUSPEND_ACTION_SELECT_SEL] = suspend_action_select;
    endfunction : mcr_exp
    function automatic int bo_cycles();
        return can_mode_pkg::BO_SEQS * can_mode_pkg::REC_BITS * can_mode_pkg::TQ_PER_BIT
            * (int'(tmp[7:0]) + 1);
    endfunction : bo_cycles
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err("run timed out");
            wrap_up();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        void'($urandom(81));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        rd_reg(can_mode_pkg::OFS_MCR);
        cmp_word(rd, can_mode_pkg::MCR_RESET);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_CFG_EN], 1'h1);
        tmp = $urandom & 32'h0000_ff00;
        wr_reg(can_mode_pkg::OFS_BTIM, tmp);
        rd_reg(can_mode_pkg::OFS_BTIM);
        cmp_word(rd, tmp);
        $display("test config done");
        wr_reg(can_mode_pkg::OFS_MCR, mcr_exp(1'h0, 1'h0, 1'h0, SOFT_SEL));
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_CFG_EN], 1'h0);
        wr_reg(can_mode_pkg::OFS_BTIM, tmp ^ 32'h0000_ff00);
        cmp_word({16'h0, bitTiming}, tmp);
        wr_reg(can_mode_pkg::OFS_GSR, 32'hffff_ffff);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_CFG_EN], 1'h0);
        axi(1'h0, 4'h2, 32'h0);
        cmp_word({30'h0, rsp}, {30'h0, can_mode_pkg::RESP_SLVERR});
        cmp_word(rd, 32'h0);
        wait_mode(BA, 1'h1, 400);
        $display("test leave_config done");
        @(posedge core_clk);
        feStatus.txBusy <= 1'h1;
        wr_reg(can_mode_pkg::OFS_MCR, mcr_exp(1'h0, 1'h1, 1'h1, SOFT_SEL));
        repeat (5 + $urandom % 16) @(posedge core_clk);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_PD_ACK], 1'h0);
        feStatus.txBusy <= 1'h0;
        n0 = 0;
        do begin
            rd_reg(can_mode_pkg::OFS_GSR);
            n0++;
        end while (!rd[can_mode_pkg::GSR_PD_ACK] && n0 < 8);
        cmp_bit(rd[can_mode_pkg::GSR_PD_ACK], 1'h1);
        burstLen <= 8'h08 + 8'($urandom % 8);
        burstGo <= 1'h1;
        @(posedge core_clk);
        burstGo <= 1'h0;
        wait_mode(WIRQ, 1'h1, 20);
        rd_reg(can_mode_pkg::OFS_IFR);
        cmp_bit(rd[can_mode_pkg::IFR_WAKE_FLAG], 1'h1);
        rd_reg(can_mode_pkg::OFS_MCR);
        cmp_word(rd, mcr_exp(1'h0, 1'h0, 1'h1, SOFT_SEL));
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_PD_ACK], 1'h0);
        wait_mode(BA, 1'h1, 400);
        wr_reg(can_mode_pkg::OFS_IFR, 32'h0000_0008);
        wait_mode(WIRQ, 1'h0, 4);
        $display("test power_down done");
        @(posedge core_clk);
        feStatus.txBusy <= 1'h1;
        dbgSuspend <= 1'h1;
        repeat (10) @(negedge core_clk);
        cmp_bit(modeOut.freeze, 1'h0);
        @(posedge core_clk);
        feStatus.txBusy <= 1'h0;
        wait_mode(FRZ, 1'h1, 10);
        cmp_bit(modeOut.busActive, 1'h0);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_SUSPEND_ACTION_SELECT_ACK], 1'h1);
        dbgSuspend <= 1'h0;
        wait_mode(FRZ, 1'h0, 10);
        cmp_bit(modeOut.busActive, 1'h0);
        wait_mode(BA, 1'h1, 400);
        $display("test soft_suspend done");
        wr_reg(can_mode_pkg::OFS_MCR, mcr_exp(1'h0, 1'h0, 1'h1, !SOFT_SEL));
        dbgSuspend <= 1'h1;
        repeat (20) @(negedge core_clk);
        cmp_bit(modeOut.freeze, 1'h0);
        cmp_bit(modeOut.busActive, 1'h1);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_SUSPEND_ACTION_SELECT_ACK], 1'h0);
        dbgSuspend <= 1'h0;
        $display("test free_suspend done");
        wr_reg(can_mode_pkg::OFS_MCR, mcr_exp(1'h0, 1'h0, 1'h1, SOFT_SEL));
        feStatus <= 3'h7;
        dbgSuspend <= 1'h1;
        n0 = cycles;
        wait_mode(FRZ, 1'h1, 8);
        rd_reg(can_mode_pkg::OFS_GSR);
        cmp_bit(rd[can_mode_pkg::GSR_BUS_OFF] & rd[can_mode_pkg::GSR_ERR_PASS], 1'h1);
        repeat (3000) @(posedge core_clk);
        dbgSuspend <= 1'h0;
        wait_mode(BON, 1'h1, 12000);
        n0 = cycles - n0;
        cmp_bit(n0 >= bo_cycles() - 8 && n0 <= bo_cycles() + 40, 1'h1);
        $display("test bus_off_suspend done");
        wrap_up();
    end
endmodule : can_mode_control_bench

bind can_mode_control can_mode_control_chk i_chk (.core_clk, .sys_rst, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .rready, .canRx, .feStatus,
    .modeOut);
